// >>> shared/slpg_pkg.sv
// Constants, types and helpers for the sleep clock gating control block
package slpg_pkg;

  // Register offsets
  localparam logic [11:0] SLPG_OFF_RUN_GATE   = 12'h108;
  localparam logic [11:0] SLPG_OFF_SLEEP_GATE = 12'h118;
  localparam logic [11:0] SLPG_OFF_DEEP_GATE  = 12'h128;
  localparam logic [11:0] SLPG_OFF_CLK_CFG    = 12'h200;
  localparam logic [11:0] SLPG_OFF_INT_STATUS = 12'h204;
  localparam logic [11:0] SLPG_OFF_INT_MASK   = 12'h208;

  // Field positions
  localparam int SLPG_BIT_PHY    = 30;
  localparam int SLPG_BIT_MAC    = 28;
  localparam int SLPG_BIT_PORT_G = 6;
  localparam int SLPG_BIT_AUTO   = 0;

  // Writable bits and reset values
  localparam logic [31:0] SLPG_GATE_WMASK = 32'h5000007f;
  localparam logic [31:0] SLPG_CFG_WMASK  = 32'h00000001;
  localparam logic [31:0] SLPG_GATE_RESET = 32'h00000000;
  localparam logic [31:0] SLPG_CFG_RESET  = 32'h00000000;

  // Units: 0..6 ports A..G, 7 MAC, 8 PHY
  localparam int          SLPG_NUM_UNITS = 9;
  localparam logic [3:0]  SLPG_UNIT_MAC  = 4'h7;
  localparam logic [3:0]  SLPG_UNIT_PHY  = 4'h8;

  // Interrupt events
  localparam int SLPG_NUM_EV   = 3;
  localparam int SLPG_EV_FAULT = 0;
  localparam int SLPG_EV_SLEEP = 1;
  localparam int SLPG_EV_WAKE  = 2;

  typedef enum {SLPG_RUN, SLPG_SLEEP, SLPG_DEEP} slpg_mode_e;

  // Gating register to per-unit enables
  function automatic logic [SLPG_NUM_UNITS-1:0] slpg_units(input logic [31:0] r);
    slpg_units = {r[SLPG_BIT_PHY], r[SLPG_BIT_MAC], r[SLPG_BIT_PORT_G:0]};
  endfunction

  // Keeps only writable gating bits
  function automatic logic [31:0] slpg_gate_bits(input logic [31:0] d);
    slpg_gate_bits = d & SLPG_GATE_WMASK;
  endfunction

endpackage

// >>> src/slpg_fault_check.sv
// Peripheral access check against the unit clock enables
module slpg_fault_check
  import slpg_pkg::*;
(
  // Clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      reset,
  // Unit clock enables
  input  wire logic [SLPG_NUM_UNITS-1:0] unit_enable,
  // Access request and answer
  input  wire logic                      access_req,
  input  wire logic [3:0]                access_unit,
  output logic                           access_ok,
  output logic                           access_fault
);

  typedef struct packed {
    logic ok;
    logic fault;
  } slpg_fc_s;

  slpg_fc_s st;
  slpg_fc_s next_st;
  logic     unit_live;

  // Next answer from the addressed unit's enable
  always_comb begin
    next_st   = '0;
    unit_live = (access_unit < 4'(SLPG_NUM_UNITS)) && unit_enable[access_unit];
    if (access_req) begin
      next_st.ok    = unit_live;
      next_st.fault = !unit_live;
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign access_ok    = st.ok;
  assign access_fault = st.fault;

endmodule // slpg_fault_check

// >>> src/slpg_irq.sv
// Sticky event status, mask and interrupt output
module slpg_irq
  import slpg_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  // Events and software writes
  input  wire logic [SLPG_NUM_EV-1:0] event_in,
  input  wire logic                   status_clear,
  input  wire logic                   mask_write,
  input  wire logic [SLPG_NUM_EV-1:0] write_data,
  // State and interrupt
  output logic      [SLPG_NUM_EV-1:0] status,
  output logic      [SLPG_NUM_EV-1:0] mask,
  output logic                        irq
);

  typedef struct packed {
    logic [SLPG_NUM_EV-1:0] status;
    logic [SLPG_NUM_EV-1:0] mask;
  } slpg_irq_s;

  slpg_irq_s st;
  slpg_irq_s next_st;

  // Write one to clear; a new event wins over the clear
  always_comb begin
    next_st = st;
    if (status_clear) begin
      next_st.status = st.status & ~write_data;
    end
    next_st.status = next_st.status | event_in;
    if (mask_write) begin
      next_st.mask = write_data;
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign status = st.status;
  assign mask   = st.mask;
  assign irq    = |(st.status & st.mask);

endmodule // slpg_irq

// >>> src/slpg_ctrl.sv
// Clock gating control with run, sleep and deep-sleep registers
module slpg_ctrl
  import slpg_pkg::*;
(
  // Clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      reset,
  // Register port
  input  wire logic [11:0]               reg_addr,
  input  wire logic [31:0]               reg_wdata,
  input  wire logic                      reg_write,
  input  wire logic                      reg_read,
  output logic      [31:0]               reg_rdata,
  // Processor power mode requests
  input  wire logic                      sleep_request,
  input  wire logic                      deep_request,
  output logic                           in_sleep,
  output logic                           in_deep_sleep,
  // Unit clock enables
  output logic      [SLPG_NUM_UNITS-1:0] unit_clock_enable,
  // Peripheral access check
  input  wire logic                      access_req,
  input  wire logic [3:0]                access_unit,
  output logic                           access_ok,
  output logic                           access_fault,
  // Interrupt
  output logic                           irq
);

  typedef struct packed {
    logic [31:0]               run_gate_reg;
    logic [31:0]               sleep_gate_reg;
    logic [31:0]               deep_sleep_gate_reg;
    logic [31:0]               run_clock_config;
    logic [1:0]                mode;
    logic [SLPG_NUM_UNITS-1:0] unit_en;
    logic [31:0]               rdata;
  } slpg_ctrl_s;

  slpg_ctrl_s             st;
  slpg_ctrl_s             next_st;
  slpg_mode_e             mode;
  slpg_mode_e             next_mode;
  logic                   auto_gating_select;
  logic [31:0]            gate_src;
  logic                   wr_status;
  logic                   wr_mask;
  logic [SLPG_NUM_EV-1:0] events;
  logic [SLPG_NUM_EV-1:0] int_status;
  logic [SLPG_NUM_EV-1:0] int_mask;

  assign mode               = slpg_mode_e'(st.mode);
  assign auto_gating_select = st.run_clock_config[SLPG_BIT_AUTO];

  // Power mode follows the processor requests
  always_comb begin
    if (deep_request) begin
      next_mode = SLPG_DEEP;
    end else if (sleep_request) begin
      next_mode = SLPG_SLEEP;
    end else begin
      next_mode = SLPG_RUN;
    end
  end

  // Gating source for the current mode
  always_comb begin
    case (mode)
      SLPG_SLEEP: begin
        gate_src = auto_gating_select ? st.sleep_gate_reg
                                      : st.run_gate_reg;
      end
      SLPG_DEEP: begin
        gate_src = auto_gating_select ? st.deep_sleep_gate_reg
                                      : st.run_gate_reg;
      end
      default: begin
        gate_src = st.run_gate_reg;
      end
    endcase
  end

  // Interrupt register write strobes
  assign wr_status = reg_write && (reg_addr == SLPG_OFF_INT_STATUS);
  assign wr_mask   = reg_write && (reg_addr == SLPG_OFF_INT_MASK);

  // Events: fault answers, sleep entry and sleep exit
  always_comb begin
    events                = '0;
    events[SLPG_EV_FAULT] = access_fault;
    events[SLPG_EV_SLEEP] = (mode == SLPG_RUN) && (next_mode != SLPG_RUN);
    events[SLPG_EV_WAKE]  = (mode != SLPG_RUN) && (next_mode == SLPG_RUN);
  end

  // Register writes, read data and clock enables
  always_comb begin
    next_st         = st;
    next_st.mode    = 2'(next_mode);
    next_st.unit_en = slpg_units(gate_src);
    next_st.rdata   = '0;
    if (reg_write) begin
      case (reg_addr)
        SLPG_OFF_RUN_GATE: begin
          next_st.run_gate_reg = slpg_gate_bits(reg_wdata);
        end
        SLPG_OFF_SLEEP_GATE: begin
          next_st.sleep_gate_reg = slpg_gate_bits(reg_wdata);
        end
        SLPG_OFF_DEEP_GATE: begin
          next_st.deep_sleep_gate_reg = slpg_gate_bits(reg_wdata);
        end
        SLPG_OFF_CLK_CFG: begin
          next_st.run_clock_config = reg_wdata & SLPG_CFG_WMASK;
        end
        default: begin
          next_st.run_clock_config = st.run_clock_config;
        end
      endcase
    end
    if (reg_read) begin
      case (reg_addr)
        SLPG_OFF_RUN_GATE: begin
          next_st.rdata = st.run_gate_reg;
        end
        SLPG_OFF_SLEEP_GATE: begin
          next_st.rdata = st.sleep_gate_reg;
        end
        SLPG_OFF_DEEP_GATE: begin
          next_st.rdata = st.deep_sleep_gate_reg;
        end
        SLPG_OFF_CLK_CFG: begin
          next_st.rdata = st.run_clock_config;
        end
        SLPG_OFF_INT_STATUS: begin
          next_st.rdata = {{(32-SLPG_NUM_EV){1'b0}}, int_status};
        end
        SLPG_OFF_INT_MASK: begin
          next_st.rdata = {{(32-SLPG_NUM_EV){1'b0}}, int_mask};
        end
        default: begin
          next_st.rdata = '0;
        end
      endcase
    end
  end

  // State register; all gating starts off
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st                     <= '0;
      st.run_gate_reg        <= SLPG_GATE_RESET;
      st.sleep_gate_reg      <= SLPG_GATE_RESET;
      st.deep_sleep_gate_reg <= SLPG_GATE_RESET;
      st.run_clock_config    <= SLPG_CFG_RESET;
      st.mode                <= 2'(SLPG_RUN);
    end else begin
      st <= next_st;
    end
  end

  // Outputs from flip-flops
  assign reg_rdata         = st.rdata;
  assign unit_clock_enable = st.unit_en;
  assign in_sleep          = (mode == SLPG_SLEEP);
  assign in_deep_sleep     = (mode == SLPG_DEEP);

  // Access check against live enables
  slpg_fault_check u_fault_check (
    .clk_sys      (clk_sys),
    .reset        (reset),
    .unit_enable  (st.unit_en),
    .access_req   (access_req),
    .access_unit  (access_unit),
    .access_ok    (access_ok),
    .access_fault (access_fault)
  );

  // Event status and interrupt
  slpg_irq u_irq (
    .clk_sys      (clk_sys),
    .reset        (reset),
    .event_in     (events),
    .status_clear (wr_status),
    .mask_write   (wr_mask),
    .write_data   (reg_wdata[SLPG_NUM_EV-1:0]),
    .status       (int_status),
    .mask         (int_mask),
    .irq          (irq)
  );

  // Helper: addressed unit is clocked
  logic unit_live;
  assign unit_live = (access_unit < 4'(SLPG_NUM_UNITS)) && st.unit_en[access_unit];

  // Sleep register empty right after reset
  a_reset_gate_zero: assert property (
    @(posedge clk_sys) $fell(reset) |-> (st.sleep_gate_reg == SLPG_GATE_RESET)
  ) else $error("sleep gate not zero after reset");

  // Sleep with auto gating drives sleep enables
  a_sleep_selects: assert property (
    @(posedge clk_sys) disable iff (reset)
    (mode == SLPG_SLEEP && auto_gating_select)
      |=> (unit_clock_enable == $past(slpg_units(st.sleep_gate_reg)))
  ) else $error("sleep enables not applied in sleep");

  // Without auto gating, run enables stay in force
  a_no_auto_run: assert property (
    @(posedge clk_sys) disable iff (reset)
    !auto_gating_select |=> (unit_clock_enable == $past(slpg_units(st.run_gate_reg)))
  ) else $error("run enables not kept without auto gating");

  // Sleep register has no effect while running
  a_run_ignores_sleep: assert property (
    @(posedge clk_sys) disable iff (reset)
    (mode == SLPG_RUN) |=> (unit_clock_enable == $past(slpg_units(st.run_gate_reg)))
  ) else $error("run mode not using run enables");

  // Access to gated unit faults next cycle
  a_gated_faults: assert property (
    @(posedge clk_sys) disable iff (reset)
    (access_req && !unit_live) |=> (access_fault && !access_ok)
  ) else $error("gated unit access did not fault");

  // Access to clocked unit completes
  a_live_completes: assert property (
    @(posedge clk_sys) disable iff (reset)
    (access_req && unit_live) |=> (access_ok && !access_fault)
  ) else $error("clocked unit access did not complete");

  // Sleep register write lands in writable bits only
  a_write_lands: assert property (
    @(posedge clk_sys) disable iff (reset)
    (reg_write && reg_addr == SLPG_OFF_SLEEP_GATE)
      |=> (st.sleep_gate_reg == ($past(reg_wdata) & SLPG_GATE_WMASK))
  ) else $error("sleep gate write wrong");

  // Reserved bits read zero
  a_reserved_zero: assert property (
    @(posedge clk_sys) disable iff (reset)
    (reg_read && reg_addr == SLPG_OFF_SLEEP_GATE)
      |=> ((reg_rdata & ~SLPG_GATE_WMASK) == 32'h00000000)
  ) else $error("reserved bits not zero");

  // Bit 30 and bit 28 steer PHY and MAC in sleep
  a_phy_mac_bits: assert property (
    @(posedge clk_sys) disable iff (reset)
    (mode == SLPG_SLEEP && auto_gating_select)
      |=> (unit_clock_enable[SLPG_UNIT_PHY] == $past(st.sleep_gate_reg[SLPG_BIT_PHY]))
       && (unit_clock_enable[SLPG_UNIT_MAC] == $past(st.sleep_gate_reg[SLPG_BIT_MAC]))
  ) else $error("PHY or MAC enable misplaced");

  // Port bits steer ports in sleep
  a_port_bits: assert property (
    @(posedge clk_sys) disable iff (reset)
    (mode == SLPG_SLEEP && auto_gating_select)
      |=> (unit_clock_enable[SLPG_BIT_PORT_G:0] == $past(st.sleep_gate_reg[SLPG_BIT_PORT_G:0]))
  ) else $error("port enables misplaced");

  // Deep-sleep with auto gating drives deep-sleep enables
  a_deep_selects: assert property (
    @(posedge clk_sys) disable iff (reset)
    (mode == SLPG_DEEP && auto_gating_select)
      |=> (unit_clock_enable == $past(slpg_units(st.deep_sleep_gate_reg)))
  ) else $error("deep-sleep enables not applied");

  // Deep request wins and enters deep-sleep next cycle
  a_mode_deep: assert property (
    @(posedge clk_sys) disable iff (reset)
    deep_request |=> (in_deep_sleep && !in_sleep)
  ) else $error("deep-sleep not entered");

  // Sleep request alone enters sleep next cycle
  a_mode_sleep: assert property (
    @(posedge clk_sys) disable iff (reset)
    (sleep_request && !deep_request) |=> (in_sleep && !in_deep_sleep)
  ) else $error("sleep not entered");

  // No request returns to run next cycle
  a_mode_run: assert property (
    @(posedge clk_sys) disable iff (reset)
    (!sleep_request && !deep_request) |=> (!in_sleep && !in_deep_sleep)
  ) else $error("run not resumed");

  // Return to run raises the wake event
  a_wake_event: assert property (
    @(posedge clk_sys) disable iff (reset)
    (mode != SLPG_RUN && !sleep_request && !deep_request)
      |=> int_status[SLPG_EV_WAKE]
  ) else $error("wake event not recorded");

  // Sleep register read returns its current contents
  a_read_sleep: assert property (
    @(posedge clk_sys) disable iff (reset)
    (reg_read && reg_addr == SLPG_OFF_SLEEP_GATE)
      |=> (reg_rdata == $past(st.sleep_gate_reg))
  ) else $error("sleep gate read wrong");

  // Read data stays zero without a read strobe
  a_rdata_idle: assert property (
    @(posedge clk_sys) disable iff (reset)
    !reg_read |=> (reg_rdata == 32'h00000000)
  ) else $error("read data not idle");

  // Sleep register holds unless written at its offset
  a_sleep_holds: assert property (
    @(posedge clk_sys) disable iff (reset)
    !(reg_write && reg_addr == SLPG_OFF_SLEEP_GATE)
      |=> $stable(st.sleep_gate_reg)
  ) else $error("sleep gate changed without write");

  // Reserved bits are never stored
  a_reserved_kept: assert property (
    @(posedge clk_sys) disable iff (reset)
    (st.sleep_gate_reg & ~SLPG_GATE_WMASK) == 32'h00000000
  ) else $error("reserved sleep gate bits stored");

  // Configuration write sets or clears auto gating
  a_cfg_write: assert property (
    @(posedge clk_sys) disable iff (reset)
    (reg_write && reg_addr == SLPG_OFF_CLK_CFG)
      |=> (auto_gating_select == $past(reg_wdata[SLPG_BIT_AUTO]))
  ) else $error("auto gating select not written");

  // At most one answer per access
  a_one_answer: assert property (
    @(posedge clk_sys) disable iff (reset)
    !(access_ok && access_fault)
  ) else $error("access both completed and faulted");

  // No request, no answer
  a_no_req_quiet: assert property (
    @(posedge clk_sys) disable iff (reset)
    !access_req |=> (!access_ok && !access_fault)
  ) else $error("answer without request");

  // A fault answer is recorded as an event
  a_fault_event: assert property (
    @(posedge clk_sys) disable iff (reset)
    access_fault |=> int_status[SLPG_EV_FAULT]
  ) else $error("fault event not recorded");

  // Run and deep-sleep gating, configuration and enables empty right after reset
  a_reset_all_zero: assert property (
    @(posedge clk_sys) $fell(reset) |->
      (st.run_gate_reg == SLPG_GATE_RESET) && (st.deep_sleep_gate_reg == SLPG_GATE_RESET)
      && (st.run_clock_config == SLPG_CFG_RESET) && (unit_clock_enable == '0)
  ) else $error("gating not empty after reset");

endmodule // slpg_ctrl

// >>> dv/tb_sleep_clock_gating_control.sv
// Self-checking bench for the sleep clock gating control block
`define CHK(g, e) check(32'(g), 32'(e))

module tb_sleep_clock_gating_control
  import slpg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // Clock and reset
  logic                      clk_sys;
  logic                      reset;
  // Register port
  logic [11:0]               reg_addr;
  logic [31:0]               reg_wdata;
  logic                      reg_write;
  logic                      reg_read;
  logic [31:0]               reg_rdata;
  // Power mode
  logic                      sleep_request;
  logic                      deep_request;
  logic                      in_sleep;
  logic                      in_deep_sleep;
  // Enables, access check, interrupt
  logic [SLPG_NUM_UNITS-1:0] unit_clock_enable;
  logic                      access_req;
  logic [3:0]                access_unit;
  logic                      access_ok;
  logic                      access_fault;
  logic                      irq;
  int                        n_fail;
  int                        n_compared;

  slpg_ctrl u_dut (
    .clk_sys           (clk_sys),
    .reset             (reset),
    .reg_addr          (reg_addr),
    .reg_wdata         (reg_wdata),
    .reg_write         (reg_write),
    .reg_read          (reg_read),
    .reg_rdata         (reg_rdata),
    .sleep_request     (sleep_request),
    .deep_request      (deep_request),
    .in_sleep          (in_sleep),
    .in_deep_sleep     (in_deep_sleep),
    .unit_clock_enable (unit_clock_enable),
    .access_req        (access_req),
    .access_unit       (access_unit),
    .access_ok         (access_ok),
    .access_fault      (access_fault),
    .irq               (irq)
  );

  // Free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Value compare with mismatch report
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Counts and verdict, then stop
  task automatic conclude();
    $display("Counts: compared=%0d mismatches=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Let n edges pass, then sample settled outputs
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // One-cycle register write
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask

  // One-cycle read, data judged in the following cycle only
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1;
    `CHK(reg_rdata, exp);
  endtask

  // Single peripheral access and its one-cycle answer
  task automatic acc(input logic [3:0] u, input logic ok, input logic flt);
    @(posedge clk_sys);
    access_req  <= 1'b1;
    access_unit <= u;
    @(posedge clk_sys);
    access_req  <= 1'b0;
    #1;
    `CHK({access_ok, access_fault}, {ok, flt});
  endtask

  // Reset contents of all gating registers
  task automatic t_reset();
    rdchk(12'h118, 32'h00000000);
    rdchk(12'h108, 32'h00000000);
    rdchk(12'h128, 32'h00000000);
    rdchk(12'h200, 32'h00000000);
    `CHK(unit_clock_enable, 9'h000);
    `CHK(irq, 1'b0);
    $display("test reset done");
  endtask

  // Reserved bits drop, offset decode, unmapped place
  task automatic t_layout();
    wr(12'h118, 32'hffffffff);
    rdchk(12'h118, 32'h5000007f);
    settle(1);
    `CHK(reg_rdata, 32'h00000000);
    wr(12'h118, 32'h00000000);
    rdchk(12'h118, 32'h00000000);
    wr(12'h300, 32'hffffffff);
    rdchk(12'h300, 32'h00000000);
    rdchk(12'h108, 32'h00000000);
    $display("test layout done");
  endtask

  // Register selection by mode and auto gating, bit mapping
  task automatic t_select();
    logic [31:0] vals [4] = '{32'h40000000, 32'h10000000, 32'h00000040, 32'h00000001};
    logic [8:0]  exps [4] = '{9'h100, 9'h080, 9'h040, 9'h001};
    wr(12'h108, 32'h00000001);
    wr(12'h118, 32'h5000007e);
    @(posedge clk_sys);
    sleep_request <= 1'b1;
    settle(3);
    `CHK(in_sleep, 1'b1);
    `CHK(unit_clock_enable, 9'h001);
    wr(12'h200, 32'h00000001);
    settle(2);
    `CHK(unit_clock_enable, 9'h1fe);
    for (int i = 0; i < 4; i++) begin
      wr(12'h118, vals[i]);
      settle(2);
      `CHK(unit_clock_enable, exps[i]);
    end
    wr(12'h128, 32'h00000002);
    @(posedge clk_sys);
    deep_request <= 1'b1;
    settle(3);
    `CHK(in_deep_sleep, 1'b1);
    `CHK(unit_clock_enable, 9'h002);
    @(posedge clk_sys);
    deep_request  <= 1'b0;
    sleep_request <= 1'b0;
    settle(3);
    `CHK({in_sleep, in_deep_sleep}, 2'b00);
    `CHK(unit_clock_enable, 9'h001);
    $display("test select done");
  endtask

  // Access to gated unit faults, event status, mask and clear
  task automatic t_fault();
    wr(12'h208, 32'h00000000);
    wr(12'h204, 32'h00000007);
    acc(4'h2, 1'b0, 1'b1);
    acc(4'h0, 1'b1, 1'b0);
    acc(4'h9, 1'b0, 1'b1);
    settle(1);
    `CHK(irq, 1'b0);
    rdchk(12'h204, 32'h00000001);
    wr(12'h208, 32'h00000001);
    settle(1);
    `CHK(irq, 1'b1);
    rdchk(12'h208, 32'h00000001);
    wr(12'h204, 32'h00000001);
    settle(1);
    `CHK(irq, 1'b0);
    rdchk(12'h204, 32'h00000000);
    $display("test fault done");
  endtask

  // Mid-run reset clears gating; deep-sleep without auto gating
  task automatic t_rereset();
    wr(12'h118, 32'h5000007f);
    wr(12'h200, 32'h00000001);
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    settle(1);
    `CHK(unit_clock_enable, 9'h000);
    rdchk(12'h118, 32'h00000000);
    rdchk(12'h200, 32'h00000000);
    wr(12'h108, 32'h10000000);
    wr(12'h128, 32'h00000004);
    @(posedge clk_sys);
    deep_request <= 1'b1;
    settle(3);
    `CHK(in_deep_sleep, 1'b1);
    `CHK(unit_clock_enable, 9'h080);
    @(posedge clk_sys);
    deep_request <= 1'b0;
    $display("test rereset done");
  endtask

  // Watchdog against a hang
  initial begin
    #100000;
    n_fail++;
    conclude();
  end

  // Main sequence
  initial begin
    n_fail        = 0;
    n_compared    = 0;
    reset         = 1'b1;
    reg_addr      = 12'h000;
    reg_wdata     = 32'h00000000;
    reg_write     = 1'b0;
    reg_read      = 1'b0;
    sleep_request = 1'b0;
    deep_request  = 1'b0;
    access_req    = 1'b0;
    access_unit   = 4'h0;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_layout();
    t_select();
    t_fault();
    t_rereset();
    conclude();
  end

endmodule // tb_sleep_clock_gating_control
